// ---- core/ch3_status_pkg.sv ----
// package: constants and carrier types for the channel 3 status flag block
// Function
// - host write of last bidir register sets bit 7; slave read clears it
// - bit 7 is an interrupt request source to the slave
// - slave write of last bidir register sets bit 6
// - host read of last bidir register or slave write of zero clears bit 6
// - host write of first bidir register sets bit 5 when bit 4 is clear
// - slave read of last bidir register clears bit 5
// - slave write of first bidir register sets bit 4 when bit 5 is clear
// - simultaneous first register writes: host wins, only bit 5 sets
// - host read of last bidir register or slave write of zero clears bit 4
// - host input data write captures address bit 2 into bit 3
// - bit 2 is a user bit, slave read/write, host read only
// - host input data write sets bit 1; slave read clears; interrupt source
// - fast gate mode substitutes its own set and clear terms for bit 1
// - slave output data write sets bit 0; host read or zero write clears
package ch3_status_pkg;
  localparam int BIDIR_IN_FULL_BIT = 7;
  localparam int BIDIR_OUT_FULL_BIT = 6;
  localparam int HOST_OWNER_BIT = 5;
  localparam int SLAVE_OWNER_BIT = 4;
  localparam int CMD_TAG_BIT = 3;
  localparam int USER_BIT = 2;
  localparam int IN_FULL_BIT = 1;
  localparam int OUT_FULL_BIT = 0;
  localparam int CMD_ADDR_BIT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // host I/O cycle events, one-cycle pulses
  typedef struct packed {
    logic wr_input_data;
    logic wr_bidir_first;
    logic wr_bidir_last;
    logic rd_bidir_last;
    logic rd_output_data;
    logic [2:0] io_addr;
  } host_ev_t;

  // slave processor events, one-cycle pulses
  typedef struct packed {
    logic rd_input_data;
    logic wr_bidir_first;
    logic rd_bidir_last;
    logic wr_bidir_last;
    logic wr_output_data;
    logic wr_status;
    logic [7:0] wdata;
  } slave_ev_t;

  // fast gate overrides for the input-full flag
  typedef struct packed {
    logic active;
    logic set;
    logic clr;
  } fast_gate_t;
endpackage

// ---- core/ch3_status_flags.sv ----
// module: channel 3 status register flag logic
`timescale 1ns/1ps
`default_nettype none
module ch3_status_flags (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // events from host port and slave core
  input wire ch3_status_pkg::host_ev_t host_ev_i,
  input wire ch3_status_pkg::slave_ev_t slave_ev_i,
  input wire ch3_status_pkg::fast_gate_t fast_gate_i,
  // status and interrupt sources
  output logic [7:0] status_o,
  output logic bidir_irq_o,
  output logic input_irq_o
);
  import ch3_status_pkg::*;


  // a status write clears a software-clearable flag only where the written
  // bit is zero, so a one written there is harmless
  function automatic logic sw_zero_clear(input slave_ev_t ev,
                                         input int pos);
    logic hit;
    hit = ev.wr_status && !ev.wdata[pos];
    return hit;
  endfunction

  // the host may claim the first bidir register only while the slave has
  // not claimed it already
  function automatic logic host_claim(input host_ev_t hev,
                                      input logic slave_owner);
    logic grant;
    grant = hev.wr_bidir_first && !slave_owner;
    return grant;
  endfunction

  // buffer full flags
  logic bidir_input_full_r;
  logic bidir_output_full_r;
  logic input_full_flag_r;
  logic output_full_flag_r;

  // ownership, tag and user bits
  logic host_write_owner_flag_r;
  logic slave_write_owner_flag_r;
  logic command_data_tag_r;
  logic user_defined_bit_r;

  // set and clear terms, one pair per flag except the tag and user bits
  logic bidir_in_set;
  logic bidir_in_clr;

  logic bidir_out_set;
  logic bidir_out_clr;

  // the host grant is shared by both owner flags
  logic host_grant;
  logic host_own_set;
  logic host_own_clr;

  logic slave_own_set;
  logic slave_own_clr;

  logic in_full_set;
  logic in_full_clr;

  logic out_full_set;
  logic out_full_clr;

  assign bidir_in_set = host_ev_i.wr_bidir_last;
  assign bidir_in_clr = slave_ev_i.rd_bidir_last;

  assign bidir_out_set = slave_ev_i.wr_bidir_last;
  assign bidir_out_clr = host_ev_i.rd_bidir_last ||
    sw_zero_clear(slave_ev_i, BIDIR_OUT_FULL_BIT);

  assign host_grant = host_claim(host_ev_i, slave_write_owner_flag_r);
  assign host_own_set = host_grant;
  assign host_own_clr = slave_ev_i.rd_bidir_last;

  // the host grant masks a slave claim made in the same cycle
  always_comb begin
    slave_own_set = 1'b0;
    if (slave_ev_i.wr_bidir_first && !host_write_owner_flag_r) begin
      slave_own_set = !host_grant;
    end
  end
  assign slave_own_clr = host_ev_i.rd_bidir_last ||
    sw_zero_clear(slave_ev_i, SLAVE_OWNER_BIT);

  // while fast gate is active its terms replace the plain host and
  // slave ones; plain events in that time are not remembered
  always_comb begin
    in_full_set = host_ev_i.wr_input_data;
    in_full_clr = slave_ev_i.rd_input_data;
    if (fast_gate_i.active) begin
      in_full_set = fast_gate_i.set;
      in_full_clr = fast_gate_i.clr;
    end
  end

  assign out_full_set = slave_ev_i.wr_output_data;
  assign out_full_clr = host_ev_i.rd_output_data ||
    sw_zero_clear(slave_ev_i, OUT_FULL_BIT);

  // set beats clear so a same-cycle set is never lost; the same-cycle clear is dropped
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bidir_input_full_r <= STATUS_RESET[BIDIR_IN_FULL_BIT];
    end
    else if (bidir_in_set) begin
      bidir_input_full_r <= 1'b1;
    end
    else if (bidir_in_clr) begin
      bidir_input_full_r <= 1'b0;
    end
  end

  // output full of the last bidir register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bidir_output_full_r <= STATUS_RESET[BIDIR_OUT_FULL_BIT];
    end
    else if (bidir_out_set) begin
      bidir_output_full_r <= 1'b1;
    end
    else if (bidir_out_clr) begin
      bidir_output_full_r <= 1'b0;
    end
  end

  // host write ownership
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_write_owner_flag_r <= STATUS_RESET[HOST_OWNER_BIT];
    end
    else if (host_own_set) begin
      host_write_owner_flag_r <= 1'b1;
    end
    else if (host_own_clr) begin
      host_write_owner_flag_r <= 1'b0;
    end
  end

  // slave write ownership
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slave_write_owner_flag_r <= STATUS_RESET[SLAVE_OWNER_BIT];
    end
    else if (slave_own_set) begin
      slave_write_owner_flag_r <= 1'b1;
    end
    else if (slave_own_clr) begin
      slave_write_owner_flag_r <= 1'b0;
    end
  end

  // the tag follows every input data write, fast gate or not
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      command_data_tag_r <= STATUS_RESET[CMD_TAG_BIT];
    end
    else if (host_ev_i.wr_input_data) begin
      command_data_tag_r <= host_ev_i.io_addr[CMD_ADDR_BIT];
    end
  end

  // the user bit has no hardware side effect
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      user_defined_bit_r <= STATUS_RESET[USER_BIT];
    end
    else if (slave_ev_i.wr_status) begin
      user_defined_bit_r <= slave_ev_i.wdata[USER_BIT];
    end
  end

  // input full of the input data register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_full_flag_r <= STATUS_RESET[IN_FULL_BIT];
    end
    else if (in_full_set) begin
      input_full_flag_r <= 1'b1;
    end
    else if (in_full_clr) begin
      input_full_flag_r <= 1'b0;
    end
  end

  // output full of the output data register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_full_flag_r <= STATUS_RESET[OUT_FULL_BIT];
    end
    else if (out_full_set) begin
      output_full_flag_r <= 1'b1;
    end
    else if (out_full_clr) begin
      output_full_flag_r <= 1'b0;
    end
  end

  // no host write path exists into the status bits
  always_comb begin
    status_o = STATUS_RESET;
    status_o[BIDIR_IN_FULL_BIT] = bidir_input_full_r;
    status_o[BIDIR_OUT_FULL_BIT] = bidir_output_full_r;
    status_o[HOST_OWNER_BIT] = host_write_owner_flag_r;
    status_o[SLAVE_OWNER_BIT] = slave_write_owner_flag_r;
    status_o[CMD_TAG_BIT] = command_data_tag_r;
    status_o[USER_BIT] = user_defined_bit_r;
    status_o[IN_FULL_BIT] = input_full_flag_r;
    status_o[OUT_FULL_BIT] = output_full_flag_r;
  end

  // the slave core takes its interrupts straight from the flag levels
  assign bidir_irq_o = bidir_input_full_r;
  assign input_irq_o = input_full_flag_r;
endmodule // ch3_status_flags
`default_nettype wire

// ---- tb/ch3_status_asserts.sv ----
// checker: temporal assertions on the channel 3 status flags
`timescale 1ns/1ps
`default_nettype none
module ch3_status_asserts (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // event inputs
  input wire ch3_status_pkg::host_ev_t host_ev_i,
  input wire ch3_status_pkg::slave_ev_t slave_ev_i,
  input wire ch3_status_pkg::fast_gate_t fast_gate_i,
  // flag outputs
  input wire logic [7:0] status_o,
  input wire logic bidir_irq_o,
  input wire logic input_irq_o
);
  import ch3_status_pkg::*;
  wire host_ev_t h = host_ev_i;
  wire slave_ev_t v = slave_ev_i;
  wire logic [7:0] s = status_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence both_first;
    h.wr_bidir_first && v.wr_bidir_first;
  endsequence
  bidir_set_a: assert property (h.wr_bidir_last |=> s[7])
    else $error("bit 7 not set");
  bidir_clr_a: assert property (v.rd_bidir_last && !h.wr_bidir_last &&
    !h.wr_bidir_first |=> !s[7] && !s[5]) else $error("bits 7 5 kept");
  irq_copy_a: assert property (bidir_irq_o == s[7] && input_irq_o == s[1])
    else $error("irq mismatch");
  out_set_a: assert property (v.wr_bidir_last |=> s[6])
    else $error("bit 6 not set");
  out_clr_a: assert property (h.rd_bidir_last && !v.wr_bidir_last &&
    !v.wr_bidir_first |=> !s[6] && !s[4]) else $error("bits 6 4 kept");
  host_prio_a: assert property (both_first ##0 !s[4] |=> s[5] && !s[4])
    else $error("priority wrong");
  cmd_tag_a: assert property (h.wr_input_data |=> s[3] == $past(h.io_addr[2]))
    else $error("tag wrong");
  user_bit_a: assert property (v.wr_status |=> s[2] == $past(v.wdata[2]))
    else $error("user bit wrong");
  slave_own_a: assert property (v.wr_bidir_first && !h.wr_bidir_first &&
    !s[5] |=> s[4]) else $error("bit 4 not set");
  gate_set_a: assert property (fast_gate_i.active && fast_gate_i.set |=> s[1])
    else $error("bit 1 not set");
  obuf_set_a: assert property (v.wr_output_data |=> s[0])
    else $error("bit 0 not set");
endmodule // ch3_status_asserts
bind ch3_status_flags ch3_status_asserts ch3_status_asserts_inst (.*);
`default_nettype wire

// ---- tb/host_io_model.sv ----
// model: host processor issuing channel 3 I/O cycles
`timescale 1ns/1ps
`default_nettype none
module host_io_model (
  // request {addr2, idr wr, first wr, last wr, last rd, odr rd}
  input wire logic [5:0] op_i,
  // host port events
  output var ch3_status_pkg::host_ev_t ev_o
);
  import ch3_status_pkg::*;
  // no status write path exists, host only reads flags
  assign ev_o = {op_i[4:0], op_i[5], 2'b01};
endmodule // host_io_model
`default_nettype wire

// ---- tb/host_channel3_status_flags_bench.sv ----
// bench: table-driven checks of the channel 3 status flags
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module host_channel3_status_flags_bench;
  import ch3_status_pkg::*;
  typedef struct packed {
    logic [5:0] h; logic [2:0] g; logic [13:0] s; logic [7:0] e;
  } row_t;
  logic clk = 0;
  logic rst_n = 0;
  logic [5:0] op = '0;
  fast_gate_t fg = '0;
  slave_ev_t sv = '0;
  host_ev_t hev;
  logic [7:0] st, x;
  logic bi, ii;
  int n_errors = 0, checked = 0, cyc = 0;
  // one event per row, back to back, except rows 12, 18 and 19, which hold two events in the same cycle; last row is idle
  row_t rows [22] = '{'{6'h04, 0, 14'h0, 8'h80}, '{0, 0, 14'h0800, 8'h00},
    '{6'h30, 0, 14'h0, 8'h0a}, '{0, 0, 14'h2000, 8'h08},
    '{6'h10, 0, 14'h0, 8'h02}, '{0, 0, 14'h0200, 8'h03},
    '{6'h01, 0, 14'h0, 8'h02}, '{0, 0, 14'h01ff, 8'h06},
    '{0, 0, 14'h0400, 8'h46}, '{0, 0, 14'h1000, 8'h56},
    '{6'h08, 0, 14'h0, 8'h56}, '{0, 0, 14'h0100, 8'h02},
    '{6'h08, 0, 14'h1000, 8'h22}, '{0, 0, 14'h1000, 8'h22},
    '{0, 0, 14'h0400, 8'h62}, '{6'h02, 0, 14'h0, 8'h22},
    '{0, 0, 14'h0800, 8'h02}, '{0, 3'h5, 14'h0, 8'h00},
    '{6'h10, 3'h4, 14'h0, 8'h00}, '{0, 3'h7, 14'h0, 8'h02},
    '{0, 0, 14'h2000, 8'h00}, '{0, 0, 14'h0, 8'h00}};
  always #25 clk = ~clk;
  host_io_model host_io_model_inst (.op_i(op), .ev_o(hev));
  ch3_status_flags ch3_status_flags_inst (.ref_clk_i(clk), .resetn_i(rst_n),
    .host_ev_i(hev), .slave_ev_i(sv), .fast_gate_i(fg), .status_o(st),
    .bidir_irq_o(bi), .input_irq_o(ii));
  task final_report;
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    `CHK({st, bi, ii}, 10'h000)
    rst_n <= 1;
    foreach (rows[i]) begin
      @(posedge clk);
      op <= rows[i].h; fg <= rows[i].g; sv <= rows[i].s;
      @(negedge clk);
      if (i > 0) begin
        x = rows[i-1].e;
        `CHK(st, x)
        `CHK({bi, ii}, {x[7], x[1]})
      end
    end
    // reset in mid-run must drop a freshly set flag
    @(posedge clk) op <= 6'h04;
    @(posedge clk) op <= 0;
    rst_n <= 0;
    @(negedge clk);
    `CHK({st, bi, ii}, 10'h000)
    // after the second release the flags work again
    @(posedge clk) rst_n <= 1;
    @(posedge clk) op <= 6'h04;
    @(posedge clk) op <= 0;
    @(negedge clk);
    `CHK({st, bi, ii}, 10'h202)
    final_report;
  end
endmodule // host_channel3_status_flags_bench
`default_nettype wire
